//--- pkg/atqr_pkg.sv
/*
 * Auto-torque tuning register bank: shared constants and types.
 * Assumes a 20 MHz system clock and 8-bit registers on a 32-bit APB bus.
 */
package atqr_pkg;

    // Bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int IDX_W = 6;
    localparam logic [1:0] WORD_ALIGN = 2'b00;

    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_INIT_HIGH = 6'h20;
    localparam logic [IDX_W-1:0] IDX_INIT_LOW = 6'h21;
    localparam logic [IDX_W-1:0] IDX_CUR_FINAL_HIGH = 6'h22;
    localparam logic [IDX_W-1:0] IDX_FINAL_LOW = 6'h23;
    localparam logic [IDX_W-1:0] IDX_BAND_UPPER = 6'h24;
    localparam logic [IDX_W-1:0] IDX_BAND_LOWER = 6'h25;
    localparam logic [IDX_W-1:0] IDX_PROP_GAIN = 6'h26;
    localparam logic [IDX_W-1:0] IDX_CONTROL = 6'h28;

    // Field positions
    localparam int HIGH_MSB = 2;
    localparam int START_CUR_LSB = 3;
    localparam int START_CUR_MSB = 7;
    localparam int ENABLE_BIT = 7;
    localparam int KICKOFF_BIT = 6;
    localparam int LOW_BYTE_LANE = 0;

    // Reset values
    localparam logic [4:0] RST_START_CURRENT = 5'h04;
    localparam logic [7:0] RST_BYTE = 8'h00;

    // Learning current: setting times eight, and the final level
    localparam int CURRENT_SHIFT = 3;
    localparam logic [7:0] FINAL_LEARN_CURRENT = 8'hff;

    // Settle time at each learning level
    localparam int CLK_MHZ = 20;
    localparam int LEARN_SETTLE_US = 1000;
    localparam int SETTLE_CYCLES = LEARN_SETTLE_US * CLK_MHZ;
    localparam int CNT_W = 20;

    // Software-visible configuration
    typedef struct packed {
        logic [2:0] init_high;
        logic [7:0] init_low;
        logic [4:0] start_cur;
        logic [2:0] final_high;
        logic [7:0] final_low;
        logic [7:0] upper;
        logic [7:0] lower;
        logic [7:0] gain;
        logic enable;
        logic kickoff;
    } atqr_cfg_type;

    // Parameters handed to the torque loop
    typedef struct packed {
        logic [10:0] learn_const_initial;
        logic [10:0] learn_const_final;
        logic [7:0] band_upper_limit;
        logic [7:0] band_lower_limit;
        logic [7:0] loop_proportional_gain;
    } atqr_tuning_type;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SETTLE_INIT,
        ST_SETTLE_FINAL
    } atqr_state_type;

endpackage

//--- src/atqr_regs.sv
/*
 * Auto-torque tuning register bank with APB slave and learning sequencer.
 * Assumes I_LOAD_COUNT comes from logic on I_CLK_SYS and the torque loop
 * consumes O_TUNING on the same clock.
 */
// The APB register port was decided locally.
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
module atqr_regs
    import atqr_pkg::*;
#(
    parameter int SETTLE_COUNT = SETTLE_CYCLES
) (
    input wire logic I_CLK_SYS, // System clock, 20 MHz
    input wire logic I_SYS_RST, // Synchronous reset, active high
    input wire logic I_PSEL, // APB select
    input wire logic I_PENABLE, // APB access phase
    input wire logic I_PWRITE, // APB direction, high for write
    input wire logic [ADDR_W-1:0] I_PADDR, // APB byte address
    input wire logic [DATA_W-1:0] I_PWDATA, // APB write data
    input wire logic [3:0] I_PSTRB, // APB byte strobes
    input wire logic [10:0] I_LOAD_COUNT, // Load counter from torque loop
    output logic O_PREADY, // APB ready
    output logic [DATA_W-1:0] O_PRDATA, // APB read data
    output logic O_PSLVERR, // APB error, unmapped address
    output atqr_tuning_type O_TUNING, // Parameters, zero when disabled
    output logic O_ADAPT_ACTIVE, // Auto-torque enabled
    output logic O_CURRENT_OVERRIDE, // Learning drives the coil current
    output logic [7:0] O_COIL_CURRENT // Learning current level
);

    //////////////////////////////////////////////////////////////////////////
    // Decoding helpers

    // Index of a word-aligned register, shared by read and write paths
    function automatic logic [IDX_W-1:0] reg_index(input logic [ADDR_W-1:0] addr);
        reg_index = addr[ADDR_W-1:2];
    endfunction

    function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
        logic [IDX_W-1:0] idx;
        idx = reg_index(addr);
        is_mapped = (addr[1:0] == WORD_ALIGN)
            && (((idx >= IDX_INIT_HIGH) && (idx <= IDX_PROP_GAIN)) || (idx == IDX_CONTROL));
    endfunction

    function automatic logic [7:0] read_value(input logic [IDX_W-1:0] idx,
                                              input atqr_cfg_type c);
        case (idx)
            IDX_INIT_HIGH: read_value = {5'h00, c.init_high};
            IDX_INIT_LOW: read_value = c.init_low;
            IDX_CUR_FINAL_HIGH: read_value = {c.start_cur, c.final_high};
            IDX_FINAL_LOW: read_value = c.final_low;
            IDX_BAND_UPPER: read_value = c.upper;
            IDX_BAND_LOWER: read_value = c.lower;
            IDX_PROP_GAIN: read_value = c.gain;
            IDX_CONTROL: read_value = {c.enable, c.kickoff, 6'h00};
            default: read_value = RST_BYTE;
        endcase
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // State

    localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_COUNT - 1);

    atqr_cfg_type cfg;
    atqr_cfg_type next_cfg;
    atqr_state_type state;
    atqr_state_type next_state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic next_pready;
    logic [DATA_W-1:0] next_prdata;
    logic next_pslverr;
    atqr_tuning_type next_tuning;
    logic next_override;
    logic [7:0] next_coil;
    logic wr_en;
    logic kick_set;
    logic [IDX_W-1:0] wr_idx;
    logic [7:0] wd;

    // Write commits only at the access edge with ready high, low lane only
    assign wr_en = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE && !O_PSLVERR
        && I_PSTRB[LOW_BYTE_LANE];
    assign wr_idx = reg_index(I_PADDR);
    assign wd = I_PWDATA[7:0];
    assign kick_set = wr_en && (wr_idx == IDX_CONTROL) && wd[KICKOFF_BIT];

    //////////////////////////////////////////////////////////////////////////
    // Next-state logic: bus, registers, learning sequencer, outputs

    always_comb begin
        next_cfg = cfg;
        next_state = state;
        next_cnt = cnt;

        // Answer one cycle after setup so read data comes from a flop
        next_pready = I_PSEL && !I_PENABLE;
        next_prdata = '0;
        next_pslverr = 1'b0;
        if (I_PSEL && !I_PENABLE) begin
            next_pslverr = !is_mapped(I_PADDR);
            next_prdata = {24'h000000, read_value(reg_index(I_PADDR), cfg)};
        end

        // Software writes
        if (wr_en) begin
            case (wr_idx)
                IDX_INIT_HIGH: next_cfg.init_high = wd[HIGH_MSB:0];
                IDX_INIT_LOW: next_cfg.init_low = wd;
                IDX_CUR_FINAL_HIGH: begin
                    next_cfg.start_cur = wd[START_CUR_MSB:START_CUR_LSB];
                    next_cfg.final_high = wd[HIGH_MSB:0];
                end
                IDX_FINAL_LOW: next_cfg.final_low = wd;
                IDX_BAND_UPPER: next_cfg.upper = wd;
                IDX_BAND_LOWER: next_cfg.lower = wd;
                IDX_PROP_GAIN: next_cfg.gain = wd;
                IDX_CONTROL: next_cfg.enable = wd[ENABLE_BIT];
                default: next_cfg = next_cfg;
            endcase
        end

        // Learning; a capture overrides a software write in the same cycle
        case (state)
            ST_IDLE: begin
                if (cfg.kickoff && cfg.enable) begin
                    next_state = ST_SETTLE_INIT;
                    next_cnt = '0;
                end else if (cfg.kickoff) begin
                    next_cfg.kickoff = 1'b0; // Nothing to learn while disabled
                end
            end
            ST_SETTLE_INIT: begin
                if (!cfg.enable) begin
                    next_state = ST_IDLE;
                    next_cfg.kickoff = 1'b0;
                end else if (cnt == SETTLE_LAST) begin
                    {next_cfg.init_high, next_cfg.init_low} = I_LOAD_COUNT;
                    next_state = ST_SETTLE_FINAL;
                    next_cnt = '0;
                end else begin
                    next_cnt = cnt + 1'b1;
                end
            end
            ST_SETTLE_FINAL: begin
                if (!cfg.enable) begin
                    next_state = ST_IDLE;
                    next_cfg.kickoff = 1'b0;
                end else if (cnt == SETTLE_LAST) begin
                    {next_cfg.final_high, next_cfg.final_low} = I_LOAD_COUNT;
                    next_state = ST_IDLE;
                    next_cfg.kickoff = 1'b0;
                end else begin
                    next_cnt = cnt + 1'b1;
                end
            end
            default: next_state = ST_IDLE;
        endcase

        // A fresh kickoff wins over the self-clear
        if (kick_set) begin
            next_cfg.kickoff = 1'b1;
        end

        // Tuning outputs gated by the enable bit
        next_tuning = '0;
        if (next_cfg.enable) begin
            next_tuning.learn_const_initial = {next_cfg.init_high, next_cfg.init_low};
            next_tuning.learn_const_final = {next_cfg.final_high, next_cfg.final_low};
            next_tuning.band_upper_limit = next_cfg.upper;
            next_tuning.band_lower_limit = next_cfg.lower;
            next_tuning.loop_proportional_gain = next_cfg.gain;
        end
        next_override = (next_state != ST_IDLE);
        if (next_state == ST_SETTLE_INIT) begin
            next_coil = {3'b000, next_cfg.start_cur} << CURRENT_SHIFT;
        end else if (next_state == ST_SETTLE_FINAL) begin
            next_coil = FINAL_LEARN_CURRENT;
        end else begin
            next_coil = RST_BYTE;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Registers

    // Every output is a flop so the loop sees glitch-free values
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SYS_RST) begin
            cfg <= '{init_high: 3'b000, init_low: RST_BYTE, start_cur: RST_START_CURRENT,
                     final_high: 3'b000, final_low: RST_BYTE, upper: RST_BYTE,
                     lower: RST_BYTE, gain: RST_BYTE, enable: 1'b0, kickoff: 1'b0};
            state <= ST_IDLE;
            cnt <= '0;
            O_PREADY <= 1'b0;
            O_PRDATA <= '0;
            O_PSLVERR <= 1'b0;
            O_TUNING <= '0;
            O_ADAPT_ACTIVE <= 1'b0;
            O_CURRENT_OVERRIDE <= 1'b0;
            O_COIL_CURRENT <= RST_BYTE;
        end else begin
            cfg <= next_cfg;
            state <= next_state;
            cnt <= next_cnt;
            O_PREADY <= next_pready;
            O_PRDATA <= next_prdata;
            O_PSLVERR <= next_pslverr;
            O_TUNING <= next_tuning;
            O_ADAPT_ACTIVE <= next_cfg.enable;
            O_CURRENT_OVERRIDE <= next_override;
            O_COIL_CURRENT <= next_coil;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (I_SYS_RST);

    logic learn_done;
    assign learn_done = (state == ST_SETTLE_FINAL) && cfg.enable && (cnt == SETTLE_LAST);

    property p_low_init_write;
        wr_en && (wr_idx == IDX_INIT_LOW) && (state != ST_SETTLE_INIT)
            |=> cfg.init_low == $past(I_PWDATA[7:0]);
    endproperty
    a_low_init_write: assert property (p_low_init_write) else $error("init low lost");

    property p_start_reset;
        $past(I_SYS_RST) |-> (cfg.start_cur == RST_START_CURRENT) && !cfg.kickoff;
    endproperty
    a_start_reset: assert property (p_start_reset) else $error("bad reset value");

    property p_init_current;
        (state == ST_SETTLE_INIT) |-> O_CURRENT_OVERRIDE
            && (O_COIL_CURRENT == ({3'b000, cfg.start_cur} << CURRENT_SHIFT));
    endproperty
    a_init_current: assert property (p_init_current) else $error("learn current not x8");

    property p_final_capture;
        learn_done |=> ({cfg.final_high, cfg.final_low} == $past(I_LOAD_COUNT))
            && (state == ST_IDLE);
    endproperty
    a_final_capture: assert property (p_final_capture) else $error("final capture wrong");

    property p_kick_clears;
        learn_done && !kick_set |=> !cfg.kickoff ##1 !O_CURRENT_OVERRIDE;
    endproperty
    a_kick_clears: assert property (p_kick_clears) else $error("kickoff not cleared");

    property p_disabled_quiet;
        !cfg.enable |-> (O_TUNING == '0) && !O_ADAPT_ACTIVE;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet) else $error("tuning leaks");

    property p_upper_applied;
        cfg.enable |-> (O_TUNING.band_upper_limit == cfg.upper)
            && (O_TUNING.learn_const_initial == {cfg.init_high, cfg.init_low});
    endproperty
    a_upper_applied: assert property (p_upper_applied) else $error("upper not applied");

    property p_lower_read;
        I_PSEL && !I_PENABLE && !I_PWRITE && (I_PADDR == {IDX_BAND_LOWER, WORD_ALIGN})
            |=> O_PREADY && !O_PSLVERR && (O_PRDATA == {24'h000000, $past(cfg.lower)});
    endproperty
    a_lower_read: assert property (p_lower_read) else $error("lower limit readback wrong");

    property p_gain_write;
        wr_en && (wr_idx == IDX_PROP_GAIN) |=> cfg.gain == $past(I_PWDATA[7:0]);
    endproperty
    a_gain_write: assert property (p_gain_write) else $error("gain not written");

    // Capture edges are left out: hardware wins there by design
    property p_split_write;
        wr_en && (wr_idx == IDX_CUR_FINAL_HIGH) && !learn_done
            |=> (cfg.final_high == $past(I_PWDATA[HIGH_MSB:0]))
            && (cfg.start_cur == $past(I_PWDATA[START_CUR_MSB:START_CUR_LSB]));
    endproperty
    a_split_write: assert property (p_split_write) else $error("split fields lost");

    property p_final_low_write;
        wr_en && (wr_idx == IDX_FINAL_LOW) && !learn_done
            |=> cfg.final_low == $past(I_PWDATA[7:0]);
    endproperty
    a_final_low_write: assert property (p_final_low_write) else $error("final low lost");

    property p_init_high_write;
        wr_en && (wr_idx == IDX_INIT_HIGH) && (state != ST_SETTLE_INIT)
            |=> cfg.init_high == $past(I_PWDATA[HIGH_MSB:0]);
    endproperty
    a_init_high_write: assert property (p_init_high_write) else $error("init high lost");

endmodule

//--- verif/atqr_regs_tb.sv
/*
 * Self-checking bench for the auto-torque tuning register bank.
 * Assumes the zero-wait APB slave and the learning sequencer of atqr_regs,
 * with the settle count shortened to 4 cycles.
 */
`timescale 1ns/1ps

module atqr_regs_tb
    import atqr_pkg::*;
;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, adapt, ovr, er;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [10:0] load_cnt;
    logic [7:0] coil;
    atqr_tuning_type tuning;
    int error_cnt = 0;
    int checks_done = 0;
    int cyc = 0;
    logic [7:0] reg_a [0:6] = '{8'h80, 8'h84, 8'h88, 8'h8c, 8'h90, 8'h94, 8'h98};
    logic [7:0] rst_v [0:6] = '{8'h00, 8'h00, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] pat_v [0:6] = '{8'ha5, 8'h3c, 8'h5e, 8'hc3, 8'h81, 8'h7e, 8'hff};
    logic [7:0] exp_v [0:6] = '{8'h05, 8'h3c, 8'h5e, 8'hc3, 8'h81, 8'h7e, 8'hff};

    atqr_regs #(.SETTLE_COUNT(4)) u_dut (
        .I_CLK_SYS(clk), .I_SYS_RST(rst), .I_PSEL(psel), .I_PENABLE(penable),
        .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .I_PSTRB(pstrb),
        .I_LOAD_COUNT(load_cnt), .O_PREADY(pready), .O_PRDATA(prdata),
        .O_PSLVERR(pslverr), .O_TUNING(tuning), .O_ADAPT_ACTIVE(adapt),
        .O_CURRENT_OVERRIDE(ovr), .O_COIL_CURRENT(coil)
    );

    ////////////////////////////////////////////////////////////////////////
    // Clock, 50 ns period
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Hang guard; the full sequence needs well under a thousand cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            give_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string what);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t %s got %b want %b", $time, what, got, exp);
        end
    endtask

    task automatic chk_tun(input atqr_tuning_type got, input atqr_tuning_type exp,
                           input string what);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // Waits on falling edges, so registered outputs have settled
    task automatic wait_out(input logic [7:0] c, input logic o, input string what);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (!(coil === c && ovr === o) && n < 100);
        chk_bit(coil === c && ovr === o, 1'b1, what);
    endtask

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                       input logic [3:0] s, output logic [31:0] rdat, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        // No cycle count assumed; only the bench timeout ends this wait
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d, 4'h1, rd, er);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input logic e_err);
        apb(1'b0, a, 8'h00, 4'h0, rd, er);
        chk_word(rd, {24'h0, e}, "read data");
        chk_bit(er, e_err, "read error flag");
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        pstrb = 4'h0;
        load_cnt = 11'h5a3;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk_tun(tuning, '0, "tuning after reset");
        chk_bit(adapt, 1'b0, "enable after reset");
        // Reset values, then a pattern written and read back
        for (int i = 0; i < 7; i++) begin
            rd_chk(reg_a[i], rst_v[i], 1'b0);
        end
        rd_chk(8'ha0, 8'h00, 1'b0);
        for (int i = 0; i < 7; i++) begin
            wr(reg_a[i], pat_v[i]);
        end
        for (int i = 0; i < 7; i++) begin
            rd_chk(reg_a[i], exp_v[i], 1'b0);
        end
        @(negedge clk);
        chk_tun(tuning, '0, "tuning while disabled");
        wr(8'ha0, 8'h80);
        repeat (2) @(negedge clk);
        chk_tun(tuning, {11'h53c, 11'h6c3, 8'h81, 8'h7e, 8'hff}, "tuning on");
        chk_bit(adapt, 1'b1, "enable flag");
        // Strobe off is ignored; unmapped and unaligned places are refused
        apb(1'b1, 8'h90, 8'h00, 4'h0, rd, er);
        rd_chk(8'h90, 8'h81, 1'b0);
        apb(1'b1, 8'h9c, 8'h55, 4'h1, rd, er);
        chk_bit(er, 1'b1, "unmapped write");
        rd_chk(8'h9c, 8'h00, 1'b1);
        // An unaligned read is flagged but still returns its word's byte
        rd_chk(8'h91, 8'h81, 1'b1);
        // Full learning run with two load readings
        wr(8'h88, 8'h18);
        wr(8'ha0, 8'hc0);
        wait_out(8'h18, 1'b1, "initial learning level");
        wait_out(8'hff, 1'b1, "final learning level");
        @(posedge clk);
        load_cnt <= 11'h2c7;
        wait_out(8'h00, 1'b0, "learning done");
        rd_chk(8'ha0, 8'h80, 1'b0);
        rd_chk(8'h80, 8'h05, 1'b0);
        rd_chk(8'h84, 8'ha3, 1'b0);
        rd_chk(8'h88, 8'h1a, 1'b0);
        rd_chk(8'h8c, 8'hc7, 1'b0);
        @(negedge clk);
        chk_tun(tuning, {11'h5a3, 11'h2c7, 8'h81, 8'h7e, 8'hff}, "learned");
        // Clearing enable mid-run aborts before the first capture
        load_cnt <= 11'h7ff;
        wr(8'ha0, 8'hc0);
        wait_out(8'h18, 1'b1, "second run started");
        wr(8'ha0, 8'h00);
        wait_out(8'h00, 1'b0, "run aborted");
        rd_chk(8'h84, 8'ha3, 1'b0);
        rd_chk(8'ha0, 8'h00, 1'b0);
        // Kickoff without enable clears itself
        wr(8'ha0, 8'h40);
        rd_chk(8'ha0, 8'h00, 1'b0);
        @(negedge clk);
        chk_bit(ovr, 1'b0, "no override while disabled");
        chk_tun(tuning, '0, "tuning disabled again");
        // Reset in mid-run aborts learning and restores the defaults
        wr(8'ha0, 8'hc0);
        wait_out(8'h18, 1'b1, "third run started");
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk_bit(ovr, 1'b0, "override after reset");
        chk_word({24'h0, coil}, 32'h0, "coil after reset");
        rd_chk(8'ha0, 8'h00, 1'b0);
        rd_chk(8'h88, 8'h20, 1'b0);
        rd_chk(8'h8c, 8'h00, 1'b0);
        give_verdict();
    end
endmodule
